// File: design/ssr_pkg.sv
// Package: register map, field positions, resets and rate table
package ssr_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] ADDR_STATUS  = 8'hC4;
	localparam logic [7:0] ADDR_DATA    = 8'hC5;
	localparam logic [7:0] ADDR_CONTROL = 8'hC3;

	// ----------------------------------------
	// Control fields
	// ----------------------------------------
	localparam int CTL_RATE_HI = 7;
	localparam int CTL_ENABLE  = 6;
	localparam int CTL_SELECT_DISABLE_BIT   = 5;
	localparam int CTL_ROLE    = 4;
	localparam int CTL_POL     = 3;
	localparam int CTL_PHASE   = 2;
	localparam int CTL_RATE_MD = 1;
	localparam int CTL_RATE_LO = 0;
	localparam logic [7:0] CTL_RESET = 8'h14;

	// ----------------------------------------
	// Status fields
	// ----------------------------------------
	localparam int STA_DONE = 7;
	localparam int STA_WRITE_COLLISION_FLAG = 6;
	localparam int STA_SERR = 5;
	localparam int STA_MODE_FAULT_FLAG = 4;
	localparam logic [3:0] STA_RSVD = 4'h0;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [6:0] HALF_ONE = 7'h01;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} ssr_bus_t;

	typedef struct packed {
		logic sck_out;
		logic sck_oe_n;
		logic mosi_out;
		logic mosi_oe_n;
		logic miso_out;
		logic miso_oe_n;
	} ssr_pins_t;

	// Half period in clocks for rate code; 0 for reserved codes
	function automatic logic [6:0] half_period(input logic [2:0] code);
		unique case (code)
			3'h1:    half_period = 7'h02;
			3'h2:    half_period = 7'h04;
			3'h3:    half_period = 7'h08;
			3'h4:    half_period = 7'h10;
			3'h5:    half_period = 7'h20;
			3'h6:    half_period = 7'h40;
			default: half_period = 7'h00;
		endcase
	endfunction

endpackage

// File: design/ssr_regs.sv
// SPI control, status and data registers with shift engine
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/10ps
module ssr_regs
(
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	input  wire ssr_pkg::ssr_bus_t bus,
	output logic [7:0]            rdata,
	input  wire logic             ss_n_in,
	input  wire logic             sck_in,
	input  wire logic             mosi_in,
	input  wire logic             miso_in,
	output ssr_pkg::ssr_pins_t    pins,
	output logic                  irq_tx,
	output logic                  irq_rx_err
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] ctl_r;
	logic       done_r, write_collision_flag_r, serr_r, mode_fault_flag_r;
	logic       sta_seen_r, mode_fault_flag_seen_r;
	logic [7:0] shift_r;
	logic [7:0] rxbuf_r;
	logic       busy_r;
	logic [2:0] bitcnt_r;
	logic [6:0] div_r;
	logic       sck_r;
	logic       phase_r;
	logic       ss_d_r, sck_d_r;
	logic       out_bit_r;
	logic       tail_r;

	logic en, select_disable_bit, master, pol, phase_bit;
	logic [6:0] half;
	logic ss_active, ss_used, mode_fault_flag_cond, mode_fault_flag_evt;
	logic wr_ctl, wr_dat, rd_sta, rd_dat;
	logic lead_edge, trail_edge, capture, launch, byte_end, serr_evt;
	logic cap_last;
	logic s_lead, s_trail, m_lead, m_trail, tick;

	assign en     = ctl_r[ssr_pkg::CTL_ENABLE];
	assign select_disable_bit  = ctl_r[ssr_pkg::CTL_SELECT_DISABLE_BIT];
	assign master = ctl_r[ssr_pkg::CTL_ROLE];
	assign pol    = ctl_r[ssr_pkg::CTL_POL];
	assign phase_bit   = ctl_r[ssr_pkg::CTL_PHASE];
	assign half   = ssr_pkg::half_period({ctl_r[ssr_pkg::CTL_RATE_HI],
		ctl_r[ssr_pkg::CTL_RATE_MD], ctl_r[ssr_pkg::CTL_RATE_LO]});

	assign wr_ctl = bus.wr && bus.addr == ssr_pkg::ADDR_CONTROL;
	assign wr_dat = bus.wr && bus.addr == ssr_pkg::ADDR_DATA;
	assign rd_sta = bus.rd && bus.addr == ssr_pkg::ADDR_STATUS;
	assign rd_dat = bus.rd && bus.addr == ssr_pkg::ADDR_DATA;

	// select use: slave phase 0 always needs SS
	assign ss_used   = !select_disable_bit || (!master && !phase_bit);
	assign ss_active = ss_used && !ss_n_in;
	// low SS while master is inconsistent
	assign mode_fault_flag_cond = en && master && !select_disable_bit && !ss_n_in;
	assign mode_fault_flag_evt  = mode_fault_flag_cond && !mode_fault_flag_r;

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			ctl_r <= ssr_pkg::CTL_RESET;
		else if (mode_fault_flag_evt)
		begin
			ctl_r[ssr_pkg::CTL_ENABLE] <= 1'b0;
			ctl_r[ssr_pkg::CTL_ROLE]   <= 1'b0;
		end
		else if (wr_ctl)
			ctl_r <= bus.wdata;
	end

	// ----------------------------------------
	// Clock divider and edges
	// ----------------------------------------
	// Reserved rate codes give no ticks, so a master stalls
	assign tick = master && busy_r && half != 7'h00 && div_r == 7'h00;
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			div_r <= 7'h00;
		else if (!busy_r || tick)
			div_r <= half - ssr_pkg::HALF_ONE;
		else
			div_r <= div_r - ssr_pkg::HALF_ONE;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ss_d_r  <= 1'b1;
			sck_d_r <= 1'b0;
		end
		else
		begin
			ss_d_r  <= ss_n_in;
			sck_d_r <= sck_in;
		end
	end

	assign s_lead  = (sck_in ^ pol) && !(sck_d_r ^ pol);
	assign s_trail = !(sck_in ^ pol) && (sck_d_r ^ pol);
	assign m_lead  = tick && !phase_r;
	assign m_trail = tick && phase_r;
	assign lead_edge  = master ? m_lead : s_lead;
	assign trail_edge = master ? m_trail : s_trail;
	assign capture = phase_bit ? trail_edge : lead_edge;
	assign launch  = phase_bit ? lead_edge : trail_edge;
	assign cap_last = busy_r && capture && bitcnt_r == ssr_pkg::BIT_LAST;
	// Master phase 0 ends on the last trailing edge: full final pulse
	assign byte_end = (master && !phase_bit) ? (busy_r && tail_r && tick)
		: cap_last;

	// ----------------------------------------
	// Shift engine
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			busy_r    <= 1'b0;
			bitcnt_r  <= 3'h0;
			shift_r   <= 8'h00;
			phase_r   <= 1'b0;
			sck_r     <= 1'b0;
			out_bit_r <= 1'b0;
			tail_r    <= 1'b0;
		end
		else if (!en)
		begin
			busy_r  <= 1'b0;
			phase_r <= 1'b0;
			sck_r   <= 1'b0;
			tail_r  <= 1'b0;
		end
		else if (!busy_r)
		begin
			phase_r <= 1'b0;
			sck_r   <= 1'b0;
			tail_r  <= 1'b0;
			// data write goes to shift register
			if (wr_dat)
			begin
				shift_r   <= bus.wdata;
				out_bit_r <= bus.wdata[7];
				busy_r    <= master;
			end
			else if (!master && (ss_active || (!ss_used && s_lead)))
				busy_r <= 1'b1;
			bitcnt_r <= 3'h0;
		end
		else
		begin
			if (tick)
			begin
				phase_r <= !phase_r;
				sck_r   <= !sck_r;
			end
			if (launch && !(phase_bit && bitcnt_r == 3'h0 && !phase_r && master))
				out_bit_r <= shift_r[7];
			if (capture)
			begin
				shift_r  <= {shift_r[6:0], master ? miso_in : mosi_in};
				bitcnt_r <= bitcnt_r + 3'h1;
			end
			if (cap_last && master && !phase_bit)
				tail_r <= 1'b1;
			if (byte_end || (!master && ss_used && ss_n_in))
				busy_r <= 1'b0;
		end
	end

	// early select release in slave receive
	assign serr_evt = en && !master && busy_r && ss_used && ss_n_in
		&& !ss_d_r && !byte_end;

	// ----------------------------------------
	// Receive buffer
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			rxbuf_r <= 8'h00;
		else if (byte_end)
			rxbuf_r <= tail_r ? shift_r
				: {shift_r[6:0], master ? miso_in : mosi_in};
	end

	// ----------------------------------------
	// Status flags
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			sta_seen_r <= 1'b0;
		else if (rd_sta)
			sta_seen_r <= 1'b1;
		else if (rd_dat || wr_dat)
			sta_seen_r <= 1'b0;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			done_r <= 1'b0;
		else if (byte_end)
			done_r <= 1'b1;
		// cleared by status then data access
		else if (busy_r || (sta_seen_r && (rd_dat || wr_dat)))
			done_r <= 1'b0;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			write_collision_flag_r <= 1'b0;
		else if (wr_dat && busy_r)
			write_collision_flag_r <= 1'b1;
		else if (sta_seen_r && (rd_dat || wr_dat))
			write_collision_flag_r <= 1'b0;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			serr_r <= 1'b0;
		else if (serr_evt)
			serr_r <= 1'b1;
		else if (!en)
			serr_r <= 1'b0;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			mode_fault_flag_seen_r <= 1'b0;
		else if (rd_sta && mode_fault_flag_r)
			mode_fault_flag_seen_r <= 1'b1;
		else if (wr_ctl)
			mode_fault_flag_seen_r <= 1'b0;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			mode_fault_flag_r <= 1'b0;
		else if (mode_fault_flag_cond)
			mode_fault_flag_r <= 1'b1;
		else if (mode_fault_flag_seen_r && wr_ctl)
			mode_fault_flag_r <= 1'b0;
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			rdata <= 8'h00;
		else if (!bus.rd)
			rdata <= 8'h00;
		else
			unique case (bus.addr)
				ssr_pkg::ADDR_STATUS:
					rdata <= {done_r, write_collision_flag_r, serr_r, mode_fault_flag_r,
						ssr_pkg::STA_RSVD};
				ssr_pkg::ADDR_DATA:    rdata <= rxbuf_r;
				ssr_pkg::ADDR_CONTROL: rdata <= ctl_r;
				default:               rdata <= 8'h00;
			endcase
	end

	// ----------------------------------------
	// Pins and requests
	// ----------------------------------------
	always_comb
	begin
		pins.sck_out   = pol ^ sck_r;
		pins.sck_oe_n  = !(en && master);
		pins.mosi_out  = out_bit_r;
		pins.mosi_oe_n = !(en && master);
		pins.miso_out  = out_bit_r;
		pins.miso_oe_n = !(en && !master && (ss_active || !ss_used));
	end

	assign irq_tx     = done_r;
	assign irq_rx_err = mode_fault_flag_r && !select_disable_bit;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_done_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		byte_end |=> done_r) else $error("done not set");
	a_write_collision_flag_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wr_dat && busy_r |=> write_collision_flag_r) else $error("write_collision_flag missing");
	a_serr_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		serr_r && $past(en) && en |-> $past(serr_r) || $past(serr_evt))
		else $error("serr changed");
	a_mode_fault_flag_drop: assert property (@(posedge clk_sys) disable iff (!rst_n)
		mode_fault_flag_evt |=> !ctl_r[ssr_pkg::CTL_ENABLE] && !master)
		else $error("fault kept role");
	a_rx_req: assert property (@(posedge clk_sys) disable iff (!rst_n)
		mode_fault_flag_cond && !wr_ctl |=> irq_rx_err) else $error("rx req");
	a_rd_status: assert property (@(posedge clk_sys) disable iff (!rst_n)
		rd_sta |=> rdata[7:4] == {$past(done_r), $past(write_collision_flag_r),
		$past(serr_r), $past(mode_fault_flag_r)}) else $error("status read");
	a_rd_data: assert property (@(posedge clk_sys) disable iff (!rst_n)
		rd_dat |=> rdata == $past(rxbuf_r)) else $error("data read");
	a_sck_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!busy_r |-> pins.sck_out == pol) else $error("sck idle");
	a_disable: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!en |=> !busy_r) else $error("busy when off");

endmodule

// File: bench/ssr_slave_model.sv
// Serial slave device model on the far side of the link
`timescale 1ns/10ps
module ssr_slave_model
(
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       sck,
	input  wire logic       mosi,
	input  wire logic       load,
	input  wire logic [7:0] reply,
	output logic            miso,
	output logic [7:0]      rx_r
);
	// ----------------------------------------
	// Idle low clock, capture on rising edge
	// ----------------------------------------
	logic       sck_r;
	logic [7:0] sr_r;

	// Limitation: only idle-low, leading-edge capture format
	assign miso = sr_r[7];

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sck_r <= 1'b0;
			sr_r  <= 8'hA5;
			rx_r  <= 8'h00;
		end
		else
		begin
			sck_r <= sck;
			if (load)
				sr_r <= reply;
			else if (sck && !sck_r)
				rx_r <= {rx_r[6:0], mosi};
			// Inverted fill so a late sample never looks valid
			else if (!sck && sck_r)
				sr_r <= {sr_r[6:0], ~sr_r[7]};
		end
	end
endmodule

// File: bench/spi_control_status_regs_tb.sv
// Self-checking bench for the serial control and status registers
`timescale 1ns/10ps
module spi_control_status_regs_tb;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic               clk_sys = 1'b0;
	logic               rst_n = 1'b0;
	ssr_pkg::ssr_bus_t  bus = '0;
	logic [7:0]         rdata;
	logic               ss_n_in = 1'b1;
	logic               sck_s = 1'b0;
	logic               mosi_s = 1'b0;
	logic               miso_in;
	ssr_pkg::ssr_pins_t pins;
	logic               irq_tx;
	logic               irq_rx_err;
	logic               ld = 1'b0;
	logic [7:0]         rep = 8'h00;
	logic [7:0]         mrx;
	logic               rd_d = 1'b0;
	logic [7:0]         hcnt = 8'h00;
	logic [7:0]         hlast = 8'h00;
	logic [7:0]         expq[$];
	logic [31:0]        seed = 32'hFFF1;
	int                 fails = 0;
	int                 check_count = 0;

	always #25 clk_sys = ~clk_sys;

	ssr_regs u_ssr_regs (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus),
		.rdata(rdata), .ss_n_in(ss_n_in), .sck_in(sck_s), .mosi_in(mosi_s),
		.miso_in(miso_in), .pins(pins), .irq_tx(irq_tx),
		.irq_rx_err(irq_rx_err));

	ssr_slave_model u_ssr_slave_model (.clk_sys(clk_sys), .rst_n(rst_n),
		.sck(pins.sck_out), .mosi(pins.mosi_out), .load(ld),
		.reply(rep), .miso(miso_in), .rx_r(mrx));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		if (fails == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys);
		bus.wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		expq.push_back(exp);
		@(posedge clk_sys);
		bus.rd <= 1'b0;
	endtask

	task automatic wait_hi();
		int n;
		n = 0;
		while (irq_rx_err !== 1'b1 && n < 3000)
		begin
			@(posedge clk_sys);
			n++;
		end
	endtask

	// Read result is only valid the cycle after the strobe
	always @(posedge clk_sys)
	begin
		if (rd_d)
			chk(rdata, expq.pop_front());
		rd_d <= bus.rd;
		if (pins.sck_out)
			hcnt <= hcnt + 8'h01;
		else if (hcnt != 8'h00)
		begin
			hlast <= hcnt;
			hcnt <= 8'h00;
		end
	end

	task automatic xfer(input logic [7:0] tx, input logic coll);
		int n;
		n = 0;
		seed = lfsr(seed);
		@(posedge clk_sys);
		rep <= seed[7:0];
		ld <= 1'b1;
		@(posedge clk_sys);
		ld <= 1'b0;
		wr(ssr_pkg::ADDR_DATA, tx);
		if (coll)
		begin
			rd(ssr_pkg::ADDR_STATUS, 8'h00);
			wr(ssr_pkg::ADDR_DATA, ~tx);
		end
		while (irq_tx !== 1'b1 && n < 3000)
		begin
			@(posedge clk_sys);
			n++;
		end
		chk({7'h00, irq_tx}, 8'h01);
		rd(ssr_pkg::ADDR_STATUS, {1'b1, coll, 6'h00});
		rd(ssr_pkg::ADDR_DATA, rep);
		rd(ssr_pkg::ADDR_STATUS, 8'h00);
		chk(mrx, tx);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		logic [2:0] c;
		logic [7:0] sb;
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd(ssr_pkg::ADDR_CONTROL, 8'h14);
		rd(ssr_pkg::ADDR_STATUS, 8'h00);
		chk({7'h00, pins.sck_oe_n}, 8'h01);
		wr(ssr_pkg::ADDR_STATUS, 8'hF0);
		rd(ssr_pkg::ADDR_STATUS, 8'h00);
		rd(8'h00, 8'h00);
		for (int i = 1; i < 7; i++)
		begin
			c = 3'(i);
			wr(ssr_pkg::ADDR_CONTROL, {c[2], 5'h1C, c[1:0]});
			seed = lfsr(seed);
			xfer(seed[15:8], i[0]);
			chk(hlast, 8'h02 << (i - 1));
		end
		// Mode fault: select driven low while master
		ss_n_in <= 1'b0;
		wr(ssr_pkg::ADDR_CONTROL, 8'h51);
		wait_hi();
		chk({7'h00, irq_rx_err}, 8'h01);
		rd(ssr_pkg::ADDR_CONTROL, 8'h01);
		rd(ssr_pkg::ADDR_STATUS, 8'h10);
		ss_n_in <= 1'b1;
		wr(ssr_pkg::ADDR_CONTROL, 8'h71);
		rd(ssr_pkg::ADDR_STATUS, 8'h00);
		// Slave receive, phase 1, select used
		seed = lfsr(seed);
		sb = seed[23:16];
		wr(ssr_pkg::ADDR_CONTROL, 8'h44);
		ss_n_in <= 1'b0;
		@(posedge clk_sys);
		@(posedge clk_sys);
		chk({7'h00, pins.miso_oe_n}, 8'h00);
		for (int b = 7; b >= 0; b--)
		begin
			repeat (2) @(posedge clk_sys);
			sck_s  <= 1'b1;
			mosi_s <= sb[b];
			repeat (2) @(posedge clk_sys);
			sck_s <= 1'b0;
		end
		// Release with the last edge so no new frame starts
		ss_n_in <= 1'b1;
		rd(ssr_pkg::ADDR_STATUS, 8'h80);
		rd(ssr_pkg::ADDR_DATA, sb);
		rd(ssr_pkg::ADDR_STATUS, 8'h00);
		// Select released mid-byte
		ss_n_in <= 1'b0;
		repeat (3) @(posedge clk_sys);
		ss_n_in <= 1'b1;
		rd(ssr_pkg::ADDR_STATUS, 8'h20);
		rd(ssr_pkg::ADDR_DATA, sb);
		rd(ssr_pkg::ADDR_STATUS, 8'h20);
		wr(ssr_pkg::ADDR_CONTROL, 8'h04);
		rd(ssr_pkg::ADDR_STATUS, 8'h00);
		wr(ssr_pkg::ADDR_CONTROL, 8'h79);
		repeat (4) @(posedge clk_sys);
		chk({7'h00, pins.sck_out}, 8'h01);
		chk({7'h00, pins.sck_oe_n}, 8'h00);
		wr(ssr_pkg::ADDR_CONTROL, 8'h39);
		repeat (4) @(posedge clk_sys);
		chk({7'h00, pins.sck_oe_n}, 8'h01);
		rd(ssr_pkg::ADDR_CONTROL, 8'h39);
		repeat (3) @(posedge clk_sys);
		test_done();
	end

	// Transfers total well under this span
	initial
	begin
		#1000000;
		fails++;
		test_done();
	end
endmodule
